// File: rtl/dadc_dev_end.sv
`timescale 1ns/10ps
`default_nettype none
module dadc_dev_end
    import dadc_pkg::*;
#(
    parameter int BURST_W = DADC_BURST_W,
    parameter int ALIGN_PERIOD = DADC_ALIGN_PERIOD
) (
    input wire logic CLOCK,
    input wire logic RST_B,
    dadc_if.dev LINK,
    input wire logic [DADC_SAMPLE_W-1:0] CHAN_A_SAMPLE,
    input wire logic [DADC_SAMPLE_W-1:0] CHAN_B_SAMPLE,
    input wire logic CHAN_A_OVER,
    input wire logic CHAN_B_OVER,
    output logic POWERED_DOWN,
    output logic BURST_ACTIVE
);
    localparam int ALIGN_CW = $clog2(ALIGN_PERIOD);

    if (BURST_W < 1 || BURST_W > DADC_CFG_W || ALIGN_PERIOD < 2) begin : g_chk
        $error("dadc_dev_end: unsupported parameters");
    end

    logic cfg_rst_n;
    logic sclk_q;
    logic sclk_rise;
    logic sclk_fall;
    logic [5:0] bit_cnt_q;
    logic [DADC_FRAME_BITS-1:0] sh_q;
    logic [DADC_FRAME_BITS-1:0] sh_next;
    logic [DADC_CFG_W-1:0] rd_sh_q;
    logic [DADC_CFG_W-1:0] mode_q;
    logic [DADC_CFG_W-1:0] burst_len_q;
    logic reading_q;
    logic drive_q;
    logic dout_q;
    logic four_wire;
    logic pd;
    logic fb_mode;
    logic align_started_q;
    logic align_rst;
    logic align_d;
    logic [ALIGN_CW-1:0] al_cnt_q;
    logic trig_q;
    logic accept;
    logic ready_q;
    logic burst_on_q;
    logic [BURST_W-1:0] burst_cnt_q;
    logic dec_a_v;
    logic dec_b_v;
    logic [DADC_SAMPLE_W-1:0] dec_a;
    logic [DADC_SAMPLE_W-1:0] dec_b;
    logic emit;
    logic tog_q;

    // Register readback mux
    function automatic logic [DADC_CFG_W-1:0] read_reg(input logic [6:0] addr,
        input logic [DADC_CFG_W-1:0] mode, input logic [DADC_CFG_W-1:0] blen,
        input logic [3:0] stat);
        if (addr == DADC_REG_MODE) begin
            return mode;
        end else if (addr == DADC_REG_BURST) begin
            return blen;
        end else if (addr == DADC_REG_STAT) begin
            return {20'h00000, stat};
        end else begin
            return '0;
        end
    endfunction

    // clear pin resets registers without clock
    assign cfg_rst_n = RST_B & LINK.cfg_regs_clear_n;
    assign four_wire = mode_q[DADC_B_4WIRE];
    assign fb_mode = mode_q[DADC_B_FBMODE];
    // pin and register both power down
    assign pd = ~LINK.chip_enable | mode_q[DADC_B_PWRDN];
    assign sclk_rise = LINK.sclk & ~sclk_q;
    assign sclk_fall = ~LINK.sclk & sclk_q;
    assign sh_next = {sh_q[DADC_FRAME_BITS-2:0], LINK.sdio};
    assign POWERED_DOWN = pd;
    assign BURST_ACTIVE = burst_on_q;

    // Serial clock edge detect
    always_ff @(posedge CLOCK or negedge cfg_rst_n) begin
        if (!cfg_rst_n) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= LINK.sclk;
        end
    end

    always_ff @(posedge CLOCK or negedge cfg_rst_n) begin
        if (!cfg_rst_n) begin
            bit_cnt_q <= 6'h00;
            sh_q <= '0;
            reading_q <= 1'b0;
        end else if (!LINK.cfg_serial_select) begin
            bit_cnt_q <= 6'h00;
            reading_q <= 1'b0;
        end else if (sclk_rise && !reading_q) begin
            sh_q <= sh_next;
            bit_cnt_q <= bit_cnt_q + 6'h01;
            if (bit_cnt_q == DADC_HDR_LAST && sh_next[7]) begin
                reading_q <= 1'b1;
            end
        end
    end

    // Register writes on last frame bit
    always_ff @(posedge CLOCK or negedge cfg_rst_n) begin
        if (!cfg_rst_n) begin
            mode_q <= DADC_MODE_RST;
            burst_len_q <= DADC_BURST_RST;
        end else if (LINK.cfg_serial_select && sclk_rise && !reading_q
                     && bit_cnt_q == DADC_FRAME_LAST && !sh_next[31]) begin
            if (sh_next[30:24] == DADC_REG_MODE) begin
                mode_q <= sh_next[23:0];
            end else if (sh_next[30:24] == DADC_REG_BURST) begin
                burst_len_q <= sh_next[23:0];
            end
        end
    end

    // Read data out on falling serial clock
    always_ff @(posedge CLOCK or negedge cfg_rst_n) begin
        if (!cfg_rst_n) begin
            rd_sh_q <= '0;
            drive_q <= 1'b0;
            dout_q <= 1'b0;
        end else if (!LINK.cfg_serial_select) begin
            drive_q <= 1'b0;
        end else if (sclk_rise && !reading_q && bit_cnt_q == DADC_HDR_LAST && sh_next[7]) begin
            rd_sh_q <= read_reg(sh_next[6:0], mode_q, burst_len_q,
                                {ready_q, burst_on_q, align_started_q, pd});
        end else if (sclk_fall && reading_q) begin
            drive_q <= 1'b1;
            dout_q <= rd_sh_q[DADC_CFG_W-1];
            rd_sh_q <= {rd_sh_q[DADC_CFG_W-2:0], 1'b0};
        end
    end

    // three-wire read drives the shared pin
    // four-wire keeps shared pin input only
    assign LINK.sdio_d_o = dout_q;
    assign LINK.sdio_d_oe = drive_q & ~four_wire;
    assign LINK.so_d_o = dout_q;
    assign LINK.so_d_oe = drive_q & four_wire;

    // only the first high alignment sample acts
    assign align_rst = LINK.align_in & ~align_started_q;

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            align_started_q <= 1'b0;
            al_cnt_q <= '0;
        end else if (align_rst) begin
            align_started_q <= 1'b1;
            al_cnt_q <= '0;
        end else if (al_cnt_q == ALIGN_CW'(ALIGN_PERIOD - 1)) begin
            al_cnt_q <= '0;
        end else begin
            al_cnt_q <= al_cnt_q + 1'b1;
        end
    end

    // periodic alignment pulse, register can mute it
    assign align_d = align_started_q & ~mode_q[DADC_B_ALNOFF] & ~pd & (al_cnt_q == '0);

    // per-channel decimators, phase reset by alignment
    dadc_decim #(.W(DADC_SAMPLE_W)) u_dec_a (
        .clk(CLOCK),
        .rst_n(RST_B),
        .clear(align_rst),
        .hipass(mode_q[DADC_B_HIPASS]),
        .sample(CHAN_A_SAMPLE),
        .valid(dec_a_v),
        .data(dec_a)
    );
    dadc_decim #(.W(DADC_SAMPLE_W)) u_dec_b (
        .clk(CLOCK),
        .rst_n(RST_B),
        .clear(align_rst),
        .hipass(mode_q[DADC_B_HIPASS]),
        .sample(CHAN_B_SAMPLE),
        .valid(dec_b_v),
        .data(dec_b)
    );

    // trigger rising edge starts a burst
    assign accept = LINK.hires_request_in & ~trig_q & ready_q & fb_mode & ~pd;

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            trig_q <= 1'b0;
            burst_on_q <= 1'b0;
            burst_cnt_q <= '0;
        end else begin
            trig_q <= LINK.hires_request_in;
            if (align_rst || pd || !fb_mode) begin
                burst_on_q <= 1'b0;
            end else if (accept) begin
                burst_on_q <= 1'b1;
                burst_cnt_q <= burst_len_q[BURST_W-1:0];
            end else if (burst_on_q) begin
                if (burst_cnt_q <= 1) begin
                    burst_on_q <= 1'b0;
                end
                burst_cnt_q <= burst_cnt_q - 1'b1;
            end
        end
    end

    // ready while idle in feedback mode
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= fb_mode & ~pd & ~burst_on_q & ~accept & ~align_rst;
        end
    end
    assign LINK.request_ready_out = ready_q;

    // burst words in feedback, filtered words in receive
    assign emit = ~pd & (fb_mode ? burst_on_q : (dec_a_v & dec_b_v));

    // Output word stage
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            tog_q <= 1'b0;
            LINK.chan_a_out_bits <= '0;
            LINK.chan_b_out_bits <= '0;
            LINK.chan_a_out_clk <= 1'b0;
            LINK.chan_b_out_clk <= 1'b0;
            LINK.hires_flag <= 1'b0;
            LINK.align_out <= 1'b0;
            LINK.chan_a_over_range <= 1'b0;
            LINK.chan_b_over_range <= 1'b0;
        end else begin
            LINK.align_out <= align_d;
            if (emit) begin
                tog_q <= ~tog_q;
                LINK.chan_a_out_bits <= burst_on_q ? CHAN_A_SAMPLE : dec_a;
                LINK.chan_b_out_bits <= burst_on_q ? CHAN_B_SAMPLE : dec_b;
                LINK.hires_flag <= burst_on_q;
            end
            // forwarded clock edge per word, polarity select
            // both clocks switch together, bus B fits A clock
            LINK.chan_a_out_clk <= (tog_q ^ emit) ^ mode_q[DADC_B_CLKFALL];
            LINK.chan_b_out_clk <= (tog_q ^ emit) ^ mode_q[DADC_B_CLKFALL];
            // over-range or alignment on the flag pin
            if (mode_q[DADC_B_OVRALN]) begin
                LINK.chan_a_over_range <= align_d;
                LINK.chan_b_over_range <= align_d;
            end else if (emit) begin
                LINK.chan_a_over_range <= CHAN_A_OVER;
                LINK.chan_b_over_range <= CHAN_B_OVER;
            end
        end
    end
endmodule
`default_nettype wire

// File: rtl/dadc_pkg.sv
package dadc_pkg;
    localparam int DADC_SAMPLE_W = 12;
    localparam int DADC_FRAME_BITS = 32;
    localparam int DADC_CFG_W = 24;
    localparam int DADC_BURST_W = 8;
    localparam int DADC_ALIGN_PERIOD = 16;
    localparam int DADC_SCLK_HALF = 4;
    // Serial frame: read flag, 7-bit address, 24-bit data, MSB first
    localparam logic [5:0] DADC_HDR_LAST = 6'h07;
    localparam logic [5:0] DADC_FRAME_LAST = 6'h1f;
    localparam logic [5:0] DADC_DATA_FIRST = 6'h08;
    // Device register indices
    localparam logic [6:0] DADC_REG_MODE = 7'h00;
    localparam logic [6:0] DADC_REG_BURST = 7'h01;
    localparam logic [6:0] DADC_REG_STAT = 7'h02;
    // Mode register fields
    localparam int DADC_B_PWRDN = 0;
    localparam int DADC_B_CLKFALL = 1;
    localparam int DADC_B_BONA = 2;
    localparam int DADC_B_ALNOFF = 3;
    localparam int DADC_B_OVRALN = 4;
    localparam int DADC_B_FBMODE = 5;
    localparam int DADC_B_HIPASS = 6;
    localparam int DADC_B_4WIRE = 16;
    localparam logic [23:0] DADC_MODE_RST = 24'h000000;
    localparam logic [23:0] DADC_BURST_RST = 24'h000040;
    // Host command port
    localparam logic [1:0] DADC_H_CMD = 2'h0;
    localparam logic [1:0] DADC_H_RD = 2'h1;
    localparam logic [1:0] DADC_H_CTRL = 2'h2;
    localparam logic [1:0] DADC_H_CAPT = 2'h3;
    localparam int DADC_H_EN = 0;
    localparam int DADC_H_ALIGN = 1;
    localparam int DADC_H_4W = 2;
    localparam int DADC_H_BONA = 3;
    localparam int DADC_H_CLR = 4;
    localparam int DADC_H_TRIG = 5;
    localparam logic [5:0] DADC_HCTRL_RST = 6'h01;
    typedef enum logic [1:0] {
        DADC_IDLE = 2'b00,
        DADC_LOW = 2'b01,
        DADC_HIGH = 2'b10,
        DADC_END = 2'b11
    } dadc_ser_t;
endpackage

// File: rtl/dadc_if.sv
`timescale 1ns/10ps
`default_nettype none
interface dadc_if
    import dadc_pkg::*;
();
    logic sclk;
    logic cfg_serial_select;
    logic sdio_h_o;
    logic sdio_h_oe;
    logic sdio_d_o;
    logic sdio_d_oe;
    logic sdio;
    logic so_d_o;
    logic so_d_oe;
    logic cfg_serial_out;
    logic cfg_regs_clear_n;
    logic chip_enable;
    logic align_in;
    logic align_out;
    logic [DADC_SAMPLE_W-1:0] chan_a_out_bits;
    logic [DADC_SAMPLE_W-1:0] chan_b_out_bits;
    logic chan_a_out_clk;
    logic chan_b_out_clk;
    logic chan_a_over_range;
    logic chan_b_over_range;
    logic hires_request_in;
    logic request_ready_out;
    logic hires_flag;
    // Wire levels from enables, pull-down when undriven
    assign sdio = sdio_d_oe ? sdio_d_o : (sdio_h_oe ? sdio_h_o : 1'b0);
    assign cfg_serial_out = so_d_oe ? so_d_o : 1'b0;
    modport dev (
        input sclk, cfg_serial_select, sdio, cfg_regs_clear_n, chip_enable,
        input align_in, hires_request_in,
        output sdio_d_o, sdio_d_oe, so_d_o, so_d_oe, align_out,
        output chan_a_out_bits, chan_b_out_bits, chan_a_out_clk, chan_b_out_clk,
        output chan_a_over_range, chan_b_over_range, request_ready_out, hires_flag
    );
    modport host (
        output sclk, cfg_serial_select, sdio_h_o, sdio_h_oe, cfg_regs_clear_n,
        output chip_enable, align_in, hires_request_in,
        input sdio, cfg_serial_out, align_out,
        input chan_a_out_bits, chan_b_out_bits, chan_a_out_clk, chan_b_out_clk,
        input chan_a_over_range, chan_b_over_range, request_ready_out, hires_flag
    );
endinterface
`default_nettype wire

// File: rtl/dadc_decim.sv
`timescale 1ns/10ps
`default_nettype none
module dadc_decim #(
    parameter int W = 12
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic hipass,
    input wire logic [W-1:0] sample,
    output logic valid,
    output logic [W-1:0] data
);
    logic phase_q;
    logic [W-1:0] hold_q;

    if (W < 2) begin : g_chk
        $error("dadc_decim: width too small");
    end

    // Halved sum or difference of two signed samples
    function automatic logic [W-1:0] half_op(input logic [W-1:0] a, input logic [W-1:0] b,
                                             input logic sub);
        logic signed [W:0] s;
        s = sub ? ($signed({a[W-1], a}) - $signed({b[W-1], b}))
                : ($signed({a[W-1], a}) + $signed({b[W-1], b}));
        return s[W:1];
    endfunction

    // pairwise filter, one output per two samples
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= 1'b0;
            hold_q <= '0;
            valid <= 1'b0;
            data <= '0;
        end else if (clear) begin
            phase_q <= 1'b0;
            valid <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
            valid <= phase_q;
            if (!phase_q) begin
                hold_q <= sample;
            end else begin
                data <= half_op(sample, hold_q, hipass);
            end
        end
    end
endmodule
`default_nettype wire

// File: rtl/dadc_host_end.sv
`timescale 1ns/10ps
`default_nettype none
module dadc_host_end
    import dadc_pkg::*;
#(
    parameter int SCLK_HALF = DADC_SCLK_HALF
) (
    input wire logic CLOCK,
    input wire logic RST_B,
    dadc_if.host LINK,
    input wire logic [1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WSTB,
    input wire logic RSTB,
    output logic [31:0] RDATA,
    output logic CAP_VALID,
    output logic [DADC_SAMPLE_W-1:0] CAP_A,
    output logic [DADC_SAMPLE_W-1:0] CAP_B,
    output logic CAP_HIRES
);
    if (SCLK_HALF < 2 || SCLK_HALF > 255) begin : g_chk
        $error("dadc_host_end: SCLK_HALF out of range");
    end

    dadc_ser_t state_q;
    logic [7:0] div_q;
    logic tick;
    logic [5:0] bit_q;
    logic [31:0] frame_q;
    logic [23:0] rx_q;
    logic [5:0] ctrl_q;
    logic trig_pend_q;
    logic rd_phase;
    logic a_clk_q;
    logic b_clk_q;
    logic a_edge;
    logic b_edge;

    assign tick = (div_q == 8'(SCLK_HALF - 1));
    assign rd_phase = frame_q[31] & (bit_q >= DADC_DATA_FIRST);

    // Half-period divider for the serial clock
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            div_q <= 8'h00;
        end else if (state_q == DADC_IDLE || tick) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // frame sent MSB first, read data sampled on rise
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= DADC_IDLE;
            bit_q <= 6'h00;
            frame_q <= 32'h00000000;
            rx_q <= 24'h000000;
            LINK.sclk <= 1'b0;
            LINK.cfg_serial_select <= 1'b0;
            LINK.sdio_h_o <= 1'b0;
        end else begin
            case (state_q)
                DADC_IDLE: begin
                    if (WSTB && ADDR == DADC_H_CMD) begin
                        frame_q <= WDATA;
                        bit_q <= 6'h00;
                        LINK.cfg_serial_select <= 1'b1;
                        LINK.sdio_h_o <= WDATA[31];
                        state_q <= DADC_LOW;
                    end
                end
                DADC_LOW: begin
                    if (tick) begin
                        LINK.sclk <= 1'b1;
                        if (rd_phase) begin
                            rx_q <= {rx_q[22:0],
                                     ctrl_q[DADC_H_4W] ? LINK.cfg_serial_out : LINK.sdio};
                        end
                        state_q <= DADC_HIGH;
                    end
                end
                DADC_HIGH: begin
                    if (tick) begin
                        LINK.sclk <= 1'b0;
                        if (bit_q == DADC_FRAME_LAST) begin
                            state_q <= DADC_END;
                        end else begin
                            bit_q <= bit_q + 6'h01;
                            LINK.sdio_h_o <= frame_q[5'(30 - bit_q)];
                            state_q <= DADC_LOW;
                        end
                    end
                end
                DADC_END: begin
                    if (tick) begin
                        LINK.cfg_serial_select <= 1'b0;
                        state_q <= DADC_IDLE;
                    end
                end
                default: begin
                    state_q <= DADC_IDLE;
                end
            endcase
        end
    end

    // release shared pin for three-wire read data
    assign LINK.sdio_h_oe = (state_q != DADC_IDLE) & ~(rd_phase & ~ctrl_q[DADC_H_4W]);

    // Control bits and trigger request
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_q <= DADC_HCTRL_RST;
            trig_pend_q <= 1'b0;
            LINK.hires_request_in <= 1'b0;
        end else begin
            if (WSTB && ADDR == DADC_H_CTRL) begin
                ctrl_q <= WDATA[5:0];
            end
            // fire only while device shows ready
            LINK.hires_request_in <= trig_pend_q & LINK.request_ready_out
                                     & ~LINK.hires_request_in;
            if (WSTB && ADDR == DADC_H_CTRL && WDATA[DADC_H_TRIG]) begin
                trig_pend_q <= 1'b1;
            end else if (trig_pend_q && LINK.request_ready_out && !LINK.hires_request_in) begin
                trig_pend_q <= 1'b0;
            end
        end
    end

    assign LINK.align_in = ctrl_q[DADC_H_ALIGN];
    // clear held low while control bit set
    assign LINK.cfg_regs_clear_n = ~ctrl_q[DADC_H_CLR];
    assign LINK.chip_enable = ctrl_q[DADC_H_EN];

    // bus B optionally taken on the A clock
    assign a_edge = LINK.chan_a_out_clk ^ a_clk_q;
    assign b_edge = ctrl_q[DADC_H_BONA] ? a_edge : (LINK.chan_b_out_clk ^ b_clk_q);

    // Word capture on each forwarded clock edge
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            a_clk_q <= 1'b0;
            b_clk_q <= 1'b0;
            CAP_VALID <= 1'b0;
            CAP_A <= '0;
            CAP_B <= '0;
            CAP_HIRES <= 1'b0;
        end else begin
            a_clk_q <= LINK.chan_a_out_clk;
            b_clk_q <= LINK.chan_b_out_clk;
            CAP_VALID <= a_edge;
            if (a_edge) begin
                CAP_A <= LINK.chan_a_out_bits;
                CAP_HIRES <= LINK.hires_flag;
            end
            if (b_edge) begin
                CAP_B <= LINK.chan_b_out_bits;
            end
        end
    end

    // Read port, data one cycle after strobe
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            RDATA <= 32'h00000000;
        end else if (RSTB) begin
            if (ADDR == DADC_H_CMD) begin
                RDATA <= frame_q;
            end else if (ADDR == DADC_H_RD) begin
                RDATA <= {state_q != DADC_IDLE, 7'h00, rx_q};
            end else if (ADDR == DADC_H_CTRL) begin
                RDATA <= {25'h0000000, trig_pend_q, ctrl_q};
            end else begin
                // over-range flags of the last word beside the capture
                RDATA <= {CAP_HIRES, 1'b0, LINK.chan_b_over_range, LINK.chan_a_over_range,
                          CAP_B, 4'h0, CAP_A};
            end
        end else begin
            RDATA <= 32'h00000000;
        end
    end
endmodule
`default_nettype wire

// File: sim/dadc_chk_sva.sv
`timescale 1ns/10ps
`default_nettype none
module dadc_chk_sva (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic cfg_serial_select,
    input wire logic sdio_d_oe,
    input wire logic so_d_oe,
    input wire logic chip_enable,
    input wire logic align_in,
    input wire logic align_out,
    input wire logic chan_a_out_clk,
    input wire logic chan_b_out_clk,
    input wire logic hires_request_in,
    input wire logic request_ready_out,
    input wire logic hires_flag
);
    logic seen_q;
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (!RST_B);
    // First alignment request seen
    always_ff @(posedge CLOCK or negedge RST_B)
        if (!RST_B)
            seen_q <= 1'b0;
        else if (align_in)
            seen_q <= 1'b1;
    property p_al_req;
        align_out |-> seen_q;
    endproperty
    a_al_req: assert property (p_al_req) else $error("align pulse too early");
    property p_sd_oe;
        sdio_d_oe |-> cfg_serial_select || $past(cfg_serial_select);
    endproperty
    a_sd_oe: assert property (p_sd_oe) else $error("shared pin driven idle");
    property p_one_oe;
        !(sdio_d_oe && so_d_oe);
    endproperty
    a_one_oe: assert property (p_one_oe) else $error("both data pins driven");
    property p_so_oe;
        so_d_oe |-> cfg_serial_select || $past(cfg_serial_select);
    endproperty
    a_so_oe: assert property (p_so_oe) else $error("serial out driven idle");
    property p_clk_pair;
        ($changed(chan_a_out_clk) == $changed(chan_b_out_clk))
            && (!$changed(hires_flag) || $changed(chan_a_out_clk));
    endproperty
    a_clk_pair: assert property (p_clk_pair) else $error("bus clocks apart");
    property p_al_pulse;
        align_out |=> !align_out [*8];
    endproperty
    a_al_pulse: assert property (p_al_pulse) else $error("align pulse too long");
    property p_pd_al;
        !$past(chip_enable) && !chip_enable |-> !align_out;
    endproperty
    a_pd_al: assert property (p_pd_al) else $error("align while off");
    property p_burst;
        $rose(hires_flag) |-> !request_ready_out && ($past(hires_request_in)
            || $past(hires_request_in, 2));
    endproperty
    a_burst: assert property (p_burst) else $error("burst without trigger");
endmodule
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import dadc_pkg::*;
();
    logic clock = 1'b0;
    logic rst_b, wstb, rstb, cap_v, cap_h, pdn;
    logic [1:0] addr;
    logic [31:0] wdata, rdata;
    logic [11:0] cap_a, cap_b;
    int bad_count, checks;
    dadc_if u_dadc_if();
    dadc_dev_end u_dadc_dev_end (.CLOCK(clock), .RST_B(rst_b), .LINK(u_dadc_if),
        .CHAN_A_SAMPLE(12'h5a3), .CHAN_B_SAMPLE(12'h1c4), .CHAN_A_OVER(1'b1),
        .CHAN_B_OVER(1'b0), .POWERED_DOWN(pdn), .BURST_ACTIVE());
    dadc_host_end u_dadc_host_end (.CLOCK(clock), .RST_B(rst_b), .LINK(u_dadc_if),
        .ADDR(addr), .WDATA(wdata), .WSTB(wstb), .RSTB(rstb), .RDATA(rdata),
        .CAP_VALID(cap_v), .CAP_A(cap_a), .CAP_B(cap_b), .CAP_HIRES(cap_h));
    dadc_chk_sva u_dadc_chk_sva (.CLOCK(clock), .RST_B(rst_b),
        .cfg_serial_select(u_dadc_if.cfg_serial_select), .sdio_d_oe(u_dadc_if.sdio_d_oe),
        .so_d_oe(u_dadc_if.so_d_oe), .chip_enable(u_dadc_if.chip_enable),
        .align_in(u_dadc_if.align_in), .align_out(u_dadc_if.align_out),
        .chan_a_out_clk(u_dadc_if.chan_a_out_clk), .chan_b_out_clk(u_dadc_if.chan_b_out_clk),
        .hires_request_in(u_dadc_if.hires_request_in),
        .request_ready_out(u_dadc_if.request_ready_out), .hires_flag(u_dadc_if.hires_flag));
    // 200 MHz clock
    always #2.5 clock = ~clock;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %h %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        if (bad_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Port cycles, each followed by an idle edge
    task automatic wr(input logic [1:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wstb <= 1'b1;
        @(posedge clock);
        wstb <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [1:0] a, output logic [31:0] v);
        addr <= a;
        rstb <= 1'b1;
        @(posedge clock);
        rstb <= 1'b0;
        #1 v = rdata;
        @(posedge clock);
    endtask
    // One serial frame, then poll until idle
    task automatic ser(input logic [31:0] cmd, input logic [23:0] exp);
        logic [31:0] v;
        int n;
        v = 32'h80000000;
        n = 0;
        wr(DADC_H_CMD, cmd);
        while (v[31] !== 1'b0 && n < 500) begin
            rd(DADC_H_RD, v);
            n++;
        end
        if (n == 500) begin
            bad_count++;
            test_done();
        end
        if (cmd[31]) chk(v, {8'h00, exp});
    endtask
    // Count captures of one kind and check their words
    task automatic cap(input int cyc, input logic h, input logic [11:0] ea, input logic [11:0] eb,
        input int nexp);
        int n;
        n = 0;
        repeat (cyc) begin
            @(posedge clock);
            #1;
            if (cap_v === 1'b1 && cap_h === h) begin
                n++;
                chk(32'(cap_a), 32'(ea));
                chk(32'(cap_b), 32'(eb));
            end
        end
        chk(n, nexp);
        @(posedge clock);
    endtask
    task automatic s_rst();
        logic [31:0] v;
        rd(DADC_H_CTRL, v);
        chk(v, 32'h00000001);
        ser({1'b1, DADC_REG_MODE, 24'h0}, DADC_MODE_RST);
        ser({1'b1, DADC_REG_BURST, 24'h0}, DADC_BURST_RST);
        ser({1'b1, 7'h05, 24'h0}, 24'h0);
        ser({1'b1, DADC_REG_STAT, 24'h0}, 24'h0);
        ser({1'b0, DADC_REG_BURST, 24'h3}, 24'h0);
        ser({1'b1, DADC_REG_BURST, 24'h0}, 24'h3);
    endtask
    task automatic s_four();
        ser({1'b0, DADC_REG_MODE, 24'h010020}, 24'h0);
        wr(DADC_H_CTRL, 32'h5);
        ser({1'b1, DADC_REG_BURST, 24'h0}, 24'h3);
    endtask
    task automatic s_burst();
        wr(DADC_H_CTRL, 32'h7);
        repeat (2) begin
            wr(DADC_H_CTRL, 32'h27);
            cap(60, 1'b1, 12'h5a3, 12'h1c4, 3);
        end
        cap(20, 1'b0, 12'h5a3, 12'h1c4, 0);
        ser({1'b1, DADC_REG_STAT, 24'h0}, 24'h00000a);
    endtask
    task automatic s_recv();
        logic [31:0] v;
        ser({1'b0, DADC_REG_MODE, 24'h010000}, 24'h0);
        wr(DADC_H_CTRL, 32'hf);
        repeat (20) @(posedge clock);
        cap(40, 1'b0, 12'h5a3, 12'h1c4, 20);
        rd(DADC_H_CAPT, v);
        chk(v, 32'h11c405a3);
        ser({1'b0, DADC_REG_MODE, 24'h010040}, 24'h0);
        repeat (20) @(posedge clock);
        cap(40, 1'b0, 12'h000, 12'h000, 20);
    endtask
    task automatic s_pwr();
        wr(DADC_H_CTRL, 32'he);
        chk(32'(pdn), 32'h1);
        wr(DADC_H_CTRL, 32'hf);
        chk(32'(pdn), 32'h0);
        ser({1'b0, DADC_REG_MODE, 24'h010001}, 24'h0);
        chk(32'(pdn), 32'h1);
        wr(DADC_H_CTRL, 32'h1b);
        wr(DADC_H_CTRL, 32'hb);
        chk(32'(pdn), 32'h0);
        ser({1'b1, DADC_REG_BURST, 24'h0}, DADC_BURST_RST);
    endtask
    // Reset, then the scenarios in order
    initial begin
        rst_b = 1'b0;
        wstb = 1'b0;
        rstb = 1'b0;
        addr = 2'h0;
        wdata = 32'h0;
        bad_count = 0;
        checks = 0;
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        s_rst();
        s_four();
        s_burst();
        s_recv();
        s_pwr();
        test_done();
    end
endmodule
`default_nettype wire
